// ===== inc/himsel_map.vh
// constants for the host interface mode select block
`ifndef HIMSEL_MAP_VH
`define HIMSEL_MAP_VH
`define HIMSEL_CFG_OFFSET 8'h02
`define HIMSEL_CFG_RESET 8'h00
`define HIMSEL_CFG_IRQSEL_BIT 5
`define HIMSEL_STRAP_MUX8_A 2'h0
`define HIMSEL_STRAP_MUX16_A 2'h1
`define HIMSEL_STRAP_MUX8_B 2'h2
`define HIMSEL_STRAP_NMUX8_B 2'h3
`define HIMSEL_MODE_MUX8_A 5'h01
`define HIMSEL_MODE_MUX16_A 5'h02
`define HIMSEL_MODE_MUX8_B 5'h04
`define HIMSEL_MODE_NMUX8_B 5'h08
`define HIMSEL_MODE_SERIAL 5'h10
`define HIMSEL_RDATA_IDLE 8'h00
`define HIMSEL_PAD_LOW 1'b0
`define HIMSEL_IRQSEL_PRIMARY 1'b0
`define HIMSEL_IRQSEL_ALTERNATE 1'b1
`endif

// ===== src/himsel_decode.v
// strap decoder for the host interface mode
`timescale 1ns/1ns
`default_nettype none
`include "himsel_map.vh"
module himsel_decode (
  input wire strap_sel_hi_i,
  input wire strap_sel_lo_i,
  input wire rd_b_i,
  input wire wr_b_i,
  output reg [4:0] mode_o
);
  // straps and strobes all low select serial, else the strap table
  always @* begin
    mode_o = `HIMSEL_MODE_MUX8_A;
    if (!strap_sel_hi_i && !strap_sel_lo_i && !rd_b_i && !wr_b_i) begin
      mode_o = `HIMSEL_MODE_SERIAL;
    end else begin
      case ({strap_sel_hi_i, strap_sel_lo_i})
        `HIMSEL_STRAP_MUX8_A: mode_o = `HIMSEL_MODE_MUX8_A;
        `HIMSEL_STRAP_MUX16_A: mode_o = `HIMSEL_MODE_MUX16_A;
        `HIMSEL_STRAP_MUX8_B: mode_o = `HIMSEL_MODE_MUX8_B;
        `HIMSEL_STRAP_NMUX8_B: mode_o = `HIMSEL_MODE_NMUX8_B;
        default: mode_o = `HIMSEL_MODE_MUX8_A;
      endcase
    end
  end
endmodule // himsel_decode
`default_nettype wire

// ===== src/himsel_top.v
// host interface mode select and interrupt pin mux
// Notes on behaviour
// - interrupt output is active low, open collector, pulled low while pending.
// - select bit 0 puts interrupt on primary pin, alternate pin is port2_bit6.
// - select bit 1 puts interrupt on alternate pin, primary outputs half-supply reference.
// - straps 00/01/10/11 pick 8-bit A, 16-bit A, 8-bit B, 8-bit non-mux B.
// - straps and read/write strobes all low at the first clock after reset select serial mode.
// - serial mode sends data to the host on an open-drain output.
// - serial mode takes host data on a pin shared with an address line.
// - straps weakly pulled low during reset, released afterwards.
`timescale 1ns/1ns
`default_nettype none
`include "himsel_map.vh"
module himsel_top #(
  // register port widths; the config register is one byte at one address
  parameter ADDR_W = 8,
  parameter DATA_W = 8
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire strap_sel_hi_i,
  input wire strap_sel_lo_i,
  input wire rd_b_i,
  input wire wr_b_i,
  input wire [ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [DATA_W-1:0] reg_wdata_i,
  output reg [DATA_W-1:0] reg_rdata_o,
  input wire irq_pending_i,
  input wire port2_bit6_out_i,
  input wire port2_bit6_oe_i,
  output wire port2_bit6_in_o,
  input wire addr_shared_i,
  output wire ser_data_in_o,
  input wire ser_data_out_i,
  output wire irq_pri_o,
  output wire irq_pri_oe_o,
  output wire half_ref_en_o,
  output wire irq_alt_o,
  output wire irq_alt_oe_o,
  input wire irq_alt_i,
  output wire ser_out_o,
  output wire ser_out_oe_o,
  output wire strap_pulldown_en_o,
  output reg [4:0] mode_o,
  output wire serial_mode_o
);
  // one-hot capture states: armed until the first clock after reset, then locked
  localparam [1:0] ST_ARMED = 2'b01;
  localparam [1:0] ST_LOCKED = 2'b10;
  // config register address at the port width
  localparam [ADDR_W-1:0] CFG_ADDR = `HIMSEL_CFG_OFFSET;

  // capture state and the config byte
  // the held mode lives in mode_o itself, so no second copy can disagree
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [4:0] mode_d;
  reg [DATA_W-1:0] cfg_q;
  reg [DATA_W-1:0] cfg_d;
  reg [DATA_W-1:0] rdata_d;
  // strap decoder result, meaningful while the straps are steady
  wire [4:0] mode_dec;
  // interrupt routing select from the config byte
  wire irq_pin_select;
  // pin mux results, one per pad function
  reg half_ref;
  reg alt_drv;
  reg alt_oe;
  reg p2_in;

  // address match for the config register; shared by write and read paths
  function cfg_hit;
    input [ADDR_W-1:0] addr;
    begin
      cfg_hit = (addr == CFG_ADDR);
    end
  endfunction

  // open-collector and open-drain pads pull low only when they own the pin
  // and have something to assert; otherwise the pad is left to its pull-up
  function oc_drive;
    input owns_pin;
    input assert_low;
    begin
      oc_drive = owns_pin & assert_low;
    end
  endfunction

  // the decoder is purely combinational; its output only matters on the
  // capture edge, so glitches while the straps settle are harmless
  himsel_decode u_decode (
    .strap_sel_hi_i(strap_sel_hi_i),
    .strap_sel_lo_i(strap_sel_lo_i),
    .rd_b_i(rd_b_i),
    .wr_b_i(wr_b_i),
    .mode_o(mode_dec)
  );

  // capture once, then hold
  // armed takes the decoded mode and locks; an unknown state also locks,
  // so a corrupted state never re-samples the straps in the middle of a run
  always @* begin
    state_d = state_q;
    mode_d = mode_o;
    case (state_q)
      ST_ARMED: begin
        state_d = ST_LOCKED;
        mode_d = mode_dec;
      end
      ST_LOCKED: begin
        state_d = ST_LOCKED;
      end
      default: begin
        state_d = ST_LOCKED;
      end
    endcase
  end

  // async reset loads constants only; the straps are read on the first clock
  // after release, so the host must keep its strobes steady through that edge
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_ARMED;
      mode_o <= `HIMSEL_MODE_MUX8_A;
    end else begin
      state_q <= state_d;
      mode_o <= mode_d;
    end
  end

  assign strap_pulldown_en_o = (state_q == ST_ARMED);
  // serial flag is a plain decode of the held mode
  assign serial_mode_o = (mode_o == `HIMSEL_MODE_SERIAL);

  // config write: other addresses are ignored and no error is flagged
  always @* begin
    cfg_d = cfg_q;
    if (reg_wr_i && cfg_hit(reg_addr_i)) begin
      cfg_d = reg_wdata_i;
    end
  end

  // config byte; reset routes the interrupt to the primary pin
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= `HIMSEL_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // read mux: unmapped addresses read as zero
  always @* begin
    rdata_d = `HIMSEL_RDATA_IDLE;
    if (cfg_hit(reg_addr_i)) begin
      rdata_d = cfg_q;
    end
  end

  // read data is registered, so it trails the address by one clock and
  // shows the byte as it stood before a write on the same edge
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= `HIMSEL_RDATA_IDLE;
    end else begin
      reg_rdata_o <= rdata_d;
    end
  end

  // interrupt routing bit; a write takes effect on the pads one clock later
  assign irq_pin_select = cfg_q[`HIMSEL_CFG_IRQSEL_BIT];

  // open collector, drives low
  // the pad value is tied low; the enable alone says whether it pulls
  assign irq_pri_o = `HIMSEL_PAD_LOW;
  assign irq_pri_oe_o = oc_drive(!irq_pin_select, irq_pending_i);

  // select 1, primary gives reference
  // the alternate pad belongs either to port logic or to the interrupt, never
  // both, so a change of select cannot make two drivers fight on it
  always @* begin
    half_ref = 1'b0;
    alt_drv = `HIMSEL_PAD_LOW;
    alt_oe = 1'b0;
    p2_in = 1'b0;
    case (irq_pin_select)
      `HIMSEL_IRQSEL_PRIMARY: begin
        alt_drv = port2_bit6_out_i;
        alt_oe = port2_bit6_oe_i;
        p2_in = irq_alt_i;
      end
      `HIMSEL_IRQSEL_ALTERNATE: begin
        half_ref = 1'b1;
        alt_oe = oc_drive(irq_pin_select, irq_pending_i);
      end
      default: begin
        half_ref = 1'b0;
      end
    endcase
  end

  // pin mux results to the pads
  assign half_ref_en_o = half_ref;
  assign irq_alt_o = alt_drv;
  assign irq_alt_oe_o = alt_oe;
  // port logic reads zero while the interrupt owns the alternate pin
  assign port2_bit6_in_o = p2_in;

  // open-drain serial out
  // a one is sent by releasing the pad, a zero by pulling it low
  assign ser_out_o = `HIMSEL_PAD_LOW;
  assign ser_out_oe_o = oc_drive(serial_mode_o, !ser_data_out_i);
  // serial input from address pin
  // gated to zero outside serial mode so the address bus never leaks through
  assign ser_data_in_o = serial_mode_o ? addr_shared_i : 1'b0;
endmodule // himsel_top
`default_nettype wire

// ===== testbench/himsel_host.sv
// host model: strap and strobe levels, pulled-up alternate pin
`timescale 1ns/1ns
`default_nettype none
module himsel_host(input wire [3:0] code_i, input wire alt_oe_i, input wire alt_drv_i,
  output wire [3:0] pins_o, output wire alt_lvl_o);
  assign pins_o = code_i;
  assign alt_lvl_o = alt_oe_i ? alt_drv_i : 1'b1; // pull-up wins when released
endmodule // himsel_host
`default_nettype wire

// ===== testbench/himsel_asserts.sv
// port checker for the mode select block
`timescale 1ns/1ns
`default_nettype none
module himsel_asserts(input wire clk_i, rst_b_i, strap_sel_hi_i, strap_sel_lo_i,
  rd_b_i, wr_b_i, irq_pending_i, addr_shared_i, ser_data_out_i, irq_pri_oe_o,
  irq_alt_oe_o, half_ref_en_o, ser_out_oe_o, ser_data_in_o, strap_pulldown_en_o,
  serial_mode_o, input wire [4:0] mode_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  reg [4:0] ex_q;
  // decode the straps each edge, compared one edge later
  always @(posedge clk_i) begin
    ex_q <= {strap_sel_hi_i, strap_sel_lo_i, rd_b_i, wr_b_i} == 4'h0 ? 5'h10 :
      5'h01 << {strap_sel_hi_i, strap_sel_lo_i};
  end
  sequence s_go; $rose(rst_b_i); endsequence
  property p_pri; !half_ref_en_o |-> irq_pri_oe_o == irq_pending_i; endproperty
  a_pri: assert property (p_pri) else $error("primary pin");
  property p_alt; half_ref_en_o |-> !irq_pri_oe_o && irq_alt_oe_o == irq_pending_i; endproperty
  a_alt: assert property (p_alt) else $error("alternate pin");
  property p_cap; s_go |=> mode_o == ex_q; endproperty
  a_cap: assert property (p_cap) else $error("mode decode");
  property p_hold; !$rose(rst_b_i) |=> $stable(mode_o); endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  property p_pd; s_go |-> strap_pulldown_en_o ##1 (!strap_pulldown_en_o)[*2]; endproperty
  a_pd: assert property (p_pd) else $error("pulldown");
  property p_so; ser_out_oe_o == (serial_mode_o && !ser_data_out_i); endproperty
  a_so: assert property (p_so) else $error("serial out");
  property p_si; ser_data_in_o == (serial_mode_o && addr_shared_i); endproperty
  a_si: assert property (p_si) else $error("serial in");
  property p_sm; serial_mode_o == mode_o[4]; endproperty
  a_sm: assert property (p_sm) else $error("serial flag");
endmodule // himsel_asserts
bind himsel_top himsel_asserts u_chk(.*);
`default_nettype wire

// ===== testbench/himsel_test.sv
// random and corner stimulus for the mode select block
`timescale 1ns/1ns
`default_nettype none
module himsel_test;
  logic clk_i=0, rst_b_i=0, reg_wr_i=0, irq_pending_i=0, addr_shared_i=0, ser_data_out_i=0;
  logic port2_bit6_out_i=0, port2_bit6_oe_i=0, sm=0;
  logic [7:0] reg_addr_i=0, reg_wdata_i=0, cfg=0, pc=0;
  logic [3:0] st=0;
  int fail_count=0, n_compared=0, seed=83, i;
  wire strap_sel_hi_i, strap_sel_lo_i, rd_b_i, wr_b_i, irq_alt_i, port2_bit6_in_o, irq_pri_o;
  wire ser_data_in_o, irq_pri_oe_o, half_ref_en_o, irq_alt_o, irq_alt_oe_o, ser_out_o;
  wire ser_out_oe_o, strap_pulldown_en_o, serial_mode_o;
  wire [7:0] reg_rdata_o;
  wire [4:0] mode_o;
  himsel_top dut(.*);
  himsel_host host(.code_i(st), .alt_oe_i(irq_alt_oe_o),
    .alt_drv_i(irq_alt_o), .pins_o({strap_sel_hi_i, strap_sel_lo_i, rd_b_i, wr_b_i}),
    .alt_lvl_o(irq_alt_i));
  initial forever #20 clk_i = ~clk_i;
  task chk(input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("Error %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // expected mode from straps and strobes at capture
  function automatic logic [7:0] exp_mode(input logic [3:0] c);
    return c == 4'h0 ? 8'h10 : 8'h01 << c[3:2];
  endfunction
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reset with code c, then scramble straps after capture
  task boot(input logic [3:0] c);
    {st, rst_b_i, reg_wr_i, cfg, sm} = {c, 1'b0, 1'b0, 8'h00, c == 4'h0};
    repeat (16) @(posedge clk_i);
    #5 chk(strap_pulldown_en_o, 8'h01);
    chk(half_ref_en_o, 8'h00);
    rst_b_i = 1;
    @(posedge clk_i);
    #5 st = ~c;
    @(posedge clk_i);
    #5 chk(mode_o, exp_mode(c));
    chk(serial_mode_o, sm);
    chk(strap_pulldown_en_o, 0);
  endtask
  initial begin
    for (i = 0; i < 6; i++) begin
      boot(i < 4 ? {i[1:0], 2'h3} : i == 4 ? 4'h0 : 4'($random(seed)));
      repeat (30) begin
        {reg_wr_i, irq_pending_i, addr_shared_i, ser_data_out_i} = 4'($random(seed));
        {port2_bit6_out_i, port2_bit6_oe_i} = 2'($random(seed));
        reg_addr_i = 8'($random(seed)) & 8'h03;
        reg_wdata_i = 8'($random(seed));
        @(posedge clk_i);
        pc = cfg;
        if (reg_wr_i && reg_addr_i == 8'h02) cfg = reg_wdata_i;
        #5 chk(half_ref_en_o, cfg[5]);
        chk({irq_pri_o, irq_pri_oe_o}, irq_pending_i && !cfg[5]);
        chk({irq_alt_o, irq_alt_oe_o},
          cfg[5] ? {1'b0, irq_pending_i} : {port2_bit6_out_i, port2_bit6_oe_i});
        chk(port2_bit6_in_o, !cfg[5] && (!port2_bit6_oe_i || port2_bit6_out_i));
        chk({ser_out_o, ser_out_oe_o}, sm && !ser_data_out_i);
        chk(ser_data_in_o, sm && addr_shared_i);
        chk(reg_rdata_o, reg_addr_i == 8'h02 ? pc : 8'h00);
      end
    end
    give_verdict;
  end
endmodule // himsel_test
`default_nettype wire
